// ### verilog/hpc_control.v
// Host port control register, address registers and halfword assembly
//
// What this block does
// - Single mode address write loads both registers
// - Single mode autoincrement bumps both registers
// - Single mode address read returns read register
// - Dual mode exposes two separate address registers
// - Halfword status bit mirrors halfword order bit
// - CPU soft reset clears both FIFOs
// - Active host cycle finishes before reset starts
// - Soft reset reads zero until reset done
// - Writing zero midway does not abort reset
// - Soft reset bit set holds ready low
// - Host fetch starts prefetch; reads return zero
// - Host sees internal ready on bit three
// - CPU reads ready bit as zero
// - CPU sets host interrupt until host clears
// - Host write one clears host interrupt
// - Writing zero leaves interrupt bits unchanged
// - Host sets CPU interrupt until CPU clears
// - CPU write one clears CPU interrupt
// - Order zero: first halfword is upper
// - Order one: first halfword is lower
// - Dual mode select bit picks address target
`timescale 1ns/1ps
`include "hpc_consts.vh"

module hpc_control (
	input  wire        sys_clk,
	input  wire        rst,
	// Host side, already in sys_clk domain
	input  wire        host_strobe,
	input  wire        host_write,
	input  wire [1:0]  host_sel,
	input  wire        host_second,
	input  wire [15:0] host_wdata,
	output reg  [15:0] host_rdata_q,
	output wire        port_ready,
	input  wire        host_busy,
	// CPU side
	input  wire        cpu_wr,
	input  wire [31:0] cpu_wdata,
	output wire [31:0] cpu_rdata,
	// Datapath handshakes
	input  wire        dma_ready,
	input  wire        addr_inc_rd,
	input  wire        addr_inc_wr,
	output reg         fetch_pulse_q,
	output wire        fifo_reset,
	output wire [31:0] read_address_reg,
	output wire [31:0] write_address_reg,
	output wire        to_host_interrupt,
	output wire        to_cpu_interrupt
);

	// =============================================================
	// State
	reg        halfword_order_q;
	reg        dual_q;
	reg        arwsel_q;
	reg        tohost_q;
	reg        tocpu_q;
	reg        srst_q;
	reg        srst_pend_q;
	reg        srst_run_q;
	reg  [3:0] srst_cnt_q;
	reg [31:0] rd_addr_q;
	reg [31:0] wr_addr_q;
	reg [15:0] first_half_q;
	reg [15:0] hold_half_q;

	wire       int_ready;
	reg  [31:0] host_view;
	reg  [31:0] cpu_view;
	reg  [31:0] rd_word;
	wire [31:0] wr_word;
	wire       wr_done;
	wire       host_ctrl_wr;
	wire       host_addr_wr;
	wire       addr_to_rd;
	wire       addr_to_wr;

	// =============================================================
	// Halfword placement
	function [31:0] hpc_join;
		input        order;
		input [15:0] first;
		input [15:0] second;
		begin
			if (order)
				hpc_join = {second, first};
			else
				hpc_join = {first, second};
		end
	endfunction

	function [15:0] hpc_pick;
		input        order;
		input        is_second;
		input [31:0] word;
		begin
			if (order ^ is_second)
				hpc_pick = word[15:0];
			else
				hpc_pick = word[31:16];
		end
	endfunction

	// Cycle type decode
	function hpc_sel_is;
		input [1:0] sel;
		input [1:0] kind;
		begin
			hpc_sel_is = (sel == kind);
		end
	endfunction

	assign wr_word = hpc_join(halfword_order_q, first_half_q, host_wdata);
	assign wr_done = host_strobe & host_write & host_second & port_ready;
	assign host_ctrl_wr = wr_done & hpc_sel_is(host_sel, `HPC_SEL_CTRL);
	assign host_addr_wr = wr_done & hpc_sel_is(host_sel, `HPC_SEL_ADDR);

	// Address target: both in single mode, chosen by select in dual mode
	assign addr_to_rd = ~dual_q | arwsel_q;
	assign addr_to_wr = ~dual_q | ~arwsel_q;

	// =============================================================
	// Ready and soft reset
	assign int_ready  = dma_ready & ~srst_run_q;
	assign port_ready = int_ready & ~srst_q;
	assign fifo_reset = srst_run_q;

	always @(posedge sys_clk) begin
		if (rst) begin
			srst_q      <= `HPC_SRST_RST;
			srst_pend_q <= 1'b0;
			srst_run_q  <= 1'b0;
			srst_cnt_q  <= 4'h0;
		end else begin
			if (cpu_wr)
				srst_q <= cpu_wdata[`HPC_SRST_BIT];
			if (cpu_wr && cpu_wdata[`HPC_SRST_BIT])
				srst_pend_q <= 1'b1;
			if (srst_pend_q && !srst_run_q && !host_busy) begin
				srst_pend_q <= 1'b0;
				srst_run_q  <= 1'b1;
				srst_cnt_q  <= `HPC_FIFO_RST_CYC;
			end else if (srst_run_q) begin
				// Runs to the end whatever the CPU writes
				if (srst_cnt_q == 4'h1)
					srst_run_q <= 1'b0;
				srst_cnt_q <= srst_cnt_q - 4'h1;
			end
		end
	end

	// =============================================================
	// Host-owned configuration bits
	always @(posedge sys_clk) begin
		if (rst) begin
			halfword_order_q        <= 1'b0;
			dual_q        <= 1'b0;
			arwsel_q      <= 1'b0;
			fetch_pulse_q <= 1'b0;
		end else begin
			fetch_pulse_q <= host_ctrl_wr & wr_word[`HPC_FETCH_BIT];
			if (host_ctrl_wr) begin
				halfword_order_q   <= wr_word[`HPC_HALFWORD_ORDER_BIT];
				dual_q   <= wr_word[`HPC_DUAL_BIT];
				arwsel_q <= wr_word[`HPC_ARWSEL_BIT];
			end
		end
	end

	// =============================================================
	// Interrupt flags, set wins over clear
	always @(posedge sys_clk) begin
		if (rst) begin
			tohost_q <= 1'b0;
			tocpu_q  <= 1'b0;
		end else begin
			if (cpu_wr && cpu_wdata[`HPC_TOHOST_BIT])
				tohost_q <= 1'b1;
			else if (host_ctrl_wr && wr_word[`HPC_TOHOST_BIT])
				tohost_q <= 1'b0;
			if (host_ctrl_wr && wr_word[`HPC_TOCPU_BIT])
				tocpu_q <= 1'b1;
			else if (cpu_wr && cpu_wdata[`HPC_TOCPU_BIT])
				tocpu_q <= 1'b0;
		end
	end

	assign to_host_interrupt = tohost_q;
	assign to_cpu_interrupt  = tocpu_q;

	// =============================================================
	// Address registers
	always @(posedge sys_clk) begin
		if (rst || srst_run_q) begin
			rd_addr_q <= `HPC_ADDR_RST;
			wr_addr_q <= `HPC_ADDR_RST;
		end else begin
			if (host_addr_wr && addr_to_rd)
				rd_addr_q <= wr_word;
			else if (addr_inc_rd || (!dual_q && addr_inc_wr))
				rd_addr_q <= rd_addr_q + 32'h00000004;
			if (host_addr_wr && addr_to_wr)
				wr_addr_q <= wr_word;
			else if (addr_inc_wr || (!dual_q && addr_inc_rd))
				wr_addr_q <= wr_addr_q + 32'h00000004;
		end
	end

	assign read_address_reg  = rd_addr_q;
	assign write_address_reg = wr_addr_q;

	// =============================================================
	// Register views
	// Host view: reserved 6-5 read zero, fetch and reset read zero
	always @* begin
		host_view                                    = 32'h00000000;
		host_view[`HPC_HALFWORD_ORDER_BIT]                     = halfword_order_q;
		host_view[`HPC_TOCPU_BIT]                    = tocpu_q;
		host_view[`HPC_TOHOST_BIT]                   = tohost_q;
		host_view[`HPC_READY_BIT]                    = int_ready;
		host_view[`HPC_FETCH_BIT]                    = 1'b0;
		host_view[`HPC_RSVD_HI_BIT:`HPC_RSVD_LO_BIT] = 2'h0;
		host_view[`HPC_SRST_BIT]                     = 1'b0;
		host_view[`HPC_HALFWORD_ORDER_STATUS_BIT]                 = halfword_order_q;
		host_view[`HPC_DUAL_BIT]                     = dual_q;
		host_view[`HPC_ARWSEL_BIT]                   = arwsel_q;
	end

	// CPU view: ready and fetch read zero, reset bit low while pending
	always @* begin
		cpu_view                                    = 32'h00000000;
		cpu_view[`HPC_HALFWORD_ORDER_BIT]                     = halfword_order_q;
		cpu_view[`HPC_TOCPU_BIT]                    = tocpu_q;
		cpu_view[`HPC_TOHOST_BIT]                   = tohost_q;
		cpu_view[`HPC_READY_BIT]                    = 1'b0;
		cpu_view[`HPC_FETCH_BIT]                    = 1'b0;
		cpu_view[`HPC_RSVD_HI_BIT:`HPC_RSVD_LO_BIT] = 2'h0;
		cpu_view[`HPC_SRST_BIT]                     = srst_q & ~srst_pend_q & ~srst_run_q;
		cpu_view[`HPC_HALFWORD_ORDER_STATUS_BIT]                 = halfword_order_q;
		cpu_view[`HPC_DUAL_BIT]                     = dual_q;
		cpu_view[`HPC_ARWSEL_BIT]                   = arwsel_q;
	end

	assign cpu_rdata = cpu_view;

	// Single mode reads the read register
	always @* begin
		case (host_sel)
			`HPC_SEL_CTRL: rd_word = host_view;
			`HPC_SEL_ADDR: begin
				if (!dual_q || arwsel_q)
					rd_word = rd_addr_q;
				else
					rd_word = wr_addr_q;
			end
			default: rd_word = 32'h00000000;
		endcase
	end

	// =============================================================
	// Halfword sequencing
	always @(posedge sys_clk) begin
		if (rst) begin
			first_half_q <= 16'h0000;
			hold_half_q  <= 16'h0000;
			host_rdata_q <= 16'h0000;
		end else if (host_strobe && port_ready) begin
			if (host_write && !host_second)
				first_half_q <= host_wdata;
			if (!host_write && !host_second) begin
				host_rdata_q <= hpc_pick(halfword_order_q, 1'b0, rd_word);
				hold_half_q  <= hpc_pick(halfword_order_q, 1'b1, rd_word);
			end else if (!host_write)
				host_rdata_q <= hold_half_q;
		end
	end

endmodule

// ### verilog/hpc_consts.vh
// Constants of the host port control register block
`ifndef HPC_CONSTS_VH
`define HPC_CONSTS_VH

// =============================================================
// Control register field positions
`define HPC_HALFWORD_ORDER_BIT       0
`define HPC_TOCPU_BIT      1
`define HPC_TOHOST_BIT     2
`define HPC_READY_BIT      3
`define HPC_FETCH_BIT      4
`define HPC_RSVD_LO_BIT    5
`define HPC_RSVD_HI_BIT    6
`define HPC_SRST_BIT       7
`define HPC_HALFWORD_ORDER_STATUS_BIT   8
`define HPC_DUAL_BIT       9
`define HPC_ARWSEL_BIT     11

// =============================================================
// Host cycle types on the control select lines
`define HPC_SEL_CTRL       2'h0
`define HPC_SEL_ADDR       2'h1
`define HPC_SEL_DATA_INC   2'h2
`define HPC_SEL_DATA       2'h3

// =============================================================
// Reset values
`define HPC_ADDR_RST       32'h00000000
`define HPC_SRST_RST       1'h0

// =============================================================
// Timing: FIFO reset sequence length, 40 ns at 10 ns per cycle
`define HPC_FIFO_RST_CYC   4'h4

`endif

// ### bench/hpc_props.sv
// Concurrent checks on the host port control block ports
`timescale 1ns/1ps
module hpc_props (
	input wire        sys_clk,
	input wire        rst,
	input wire        host_busy,
	input wire        cpu_wr,
	input wire [31:0] cpu_wdata,
	input wire [31:0] cpu_rdata,
	input wire        port_ready,
	input wire        fifo_reset,
	input wire [31:0] read_address_reg,
	input wire [31:0] write_address_reg,
	input wire        to_host_interrupt,
	input wire        to_cpu_interrupt
);
	// ==========
	// Properties
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence reset_run_s;
		fifo_reset [*4] ##1 !fifo_reset;
	endsequence
	fifo_len_a: assert property ($rose(fifo_reset) |-> reset_run_s)
		else $error("fifo reset length");
	busy_defer_a: assert property (host_busy |=> !$rose(fifo_reset))
		else $error("reset began in host cycle");
	reset_block_a: assert property (fifo_reset |-> !port_ready && !cpu_rdata[7])
		else $error("ready during fifo reset");
	order_mirror_a: assert property (cpu_rdata[8] == cpu_rdata[0])
		else $error("order status");
	cpu_zero_a: assert property (cpu_rdata[6:3] == 4'h0)
		else $error("cpu zero bits");
	same_addr_a: assert property (!cpu_rdata[9] && read_address_reg == write_address_reg
		|=> read_address_reg == write_address_reg) else $error("single mode split");
	to_host_interrupt_set_a: assert property (cpu_wr && cpu_wdata[2] |=> to_host_interrupt)
		else $error("host interrupt not set");
	irq_level_a: assert property (to_host_interrupt == cpu_rdata[2]
		&& to_cpu_interrupt == cpu_rdata[1]) else $error("interrupt level");
endmodule

// ### bench/hpc_host_model.sv
// Host side model driving the halfword control port
`timescale 1ns/1ps
module hpc_host_model (
	input  wire        sys_clk,
	input  wire        port_ready,
	input  wire [15:0] host_rdata_q,
	output reg         host_strobe,
	output reg         host_write,
	output reg  [1:0]  host_sel,
	output reg         host_second,
	output reg  [15:0] host_wdata
);
	reg order_q = 1'b0;
	integer stalls = 0;
	initial {host_strobe, host_write, host_sel, host_second, host_wdata} = 21'h0;
	// ==========
	// Two halfword transfer
	task xfer(input w, input [1:0] s, input [31:0] d, output [31:0] q);
		integer     i;
		integer     n;
		reg  [15:0] h;
		begin
			q = 32'h0;
			for (i = 0; i < 2; i = i + 1) begin
				h = (i[0] ^ order_q) ? d[15:0] : d[31:16];
				for (n = 0; !port_ready && n < 50; n = n + 1) @(negedge sys_clk);
				if (!port_ready) stalls = stalls + 1;
				{host_strobe, host_write, host_sel, host_second, host_wdata} = {1'b1, w, s, i[0], h};
				@(negedge sys_clk);
				if (i[0] ^ order_q) q[15:0] = host_rdata_q;
				else q[31:16] = host_rdata_q;
			end
			{host_strobe, host_wdata} = {1'b0, ~h};
			@(negedge sys_clk);
			if (w && s == 2'h0) order_q = d[0];
		end
	endtask
endmodule

// ### bench/test_hpc_control.sv
// Self-checking bench for the host port control block
`timescale 1ns/1ps
module test_hpc_control;
	reg         sys_clk = 0, rst = 1, host_busy = 0, cpu_wr = 0, dma_ready = 1;
	reg         addr_inc_rd = 0, addr_inc_wr = 0;
	reg  [31:0] cpu_wdata = 0, q, v, w, mode;
	wire [31:0] cpu_rdata, read_address_reg, write_address_reg;
	wire [15:0] host_wdata, host_rdata_q;
	wire [1:0]  host_sel;
	wire        host_strobe, host_write, host_second, port_ready, fetch_pulse_q;
	wire        fifo_reset, to_host_interrupt, to_cpu_interrupt;
	integer     failures = 0, num_checks = 0, seed = 43089, i, n, fetches = 0;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (fetch_pulse_q === 1'b1) fetches <= fetches + 1;
	hpc_control u_dut (.sys_clk, .rst, .host_strobe, .host_write, .host_sel, .host_second,
		.host_wdata, .host_rdata_q, .port_ready, .host_busy, .cpu_wr, .cpu_wdata, .cpu_rdata,
		.dma_ready, .addr_inc_rd, .addr_inc_wr, .fetch_pulse_q, .fifo_reset,
		.read_address_reg, .write_address_reg, .to_host_interrupt, .to_cpu_interrupt);
	hpc_host_model u_host (.sys_clk, .port_ready, .host_rdata_q, .host_strobe, .host_write,
		.host_sel, .host_second, .host_wdata);
	// ==========
	// Shared tasks
	task chk(input ok, input string m);
		begin
			num_checks = num_checks + 1;
			if (!ok) begin
				failures = failures + 1;
				$display("CHECK FAILED %0t %s", $time, m);
			end
		end
	endtask
	task cpu(input [31:0] d);
		begin
			{cpu_wr, cpu_wdata} = {1'b1, d};
			@(negedge sys_clk);
			cpu_wr = 1'b0;
			@(negedge sys_clk);
		end
	endtask
	task hw(input [31:0] b);
		u_host.xfer(1'b1, 2'h0, (mode | b) & 32'hFFFFFF9F, q);
	endtask
	task bump(input rd);
		begin
			{addr_inc_rd, addr_inc_wr} = {rd, !rd};
			@(negedge sys_clk);
			{addr_inc_rd, addr_inc_wr} = 2'h0;
			@(negedge sys_clk);
		end
	endtask
	task wrap_up;
		begin
			failures = failures + u_host.stalls;
			$display("checks %0d failures %0d", num_checks, failures);
			if (failures == 0 && num_checks > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	// ==========
	// Scenarios
	initial begin
		repeat (2) @(negedge sys_clk);
		rst = 0;
		chk(cpu_rdata === 32'h0, "reset view");
		u_host.xfer(1'b0, 2'h0, 32'h0, q);
		chk(q === 32'h8, "host ready bit");
		for (i = 0; i < 2; i = i + 1) begin
			mode = i;
			hw(32'h0);
			chk(cpu_rdata[8] === i[0], "order status");
			v = $random(seed) & 32'hFFFFFFFC;
			u_host.xfer(1'b1, 2'h1, v, q);
			chk(read_address_reg === v && write_address_reg === v, "single load");
			u_host.xfer(1'b0, 2'h1, 32'h0, q);
			chk(q === v, "single read");
			bump(1'b1);
			chk(read_address_reg === v + 4 && write_address_reg === v + 4, "inc");
			$display("order %0d test done", i);
		end
		mode = 32'h200;
		hw(32'h0);
		v = $random(seed) & 32'hFFFFFFFC;
		w = ~v & 32'hFFFFFFFC;
		u_host.xfer(1'b1, 2'h1, v, q);
		mode = 32'hA00;
		hw(32'h0);
		u_host.xfer(1'b1, 2'h1, w, q);
		bump(1'b0);
		chk(write_address_reg === v + 4 && read_address_reg === w, "dual regs");
		cpu(32'h4);
		chk(to_host_interrupt === 1'b1, "host irq set");
		cpu(32'h0);
		hw(32'h0);
		chk(to_host_interrupt === 1'b1, "zero write kept");
		hw(32'h4);
		hw(32'h2);
		chk({to_host_interrupt, to_cpu_interrupt} === 2'h1, "host clear, cpu set");
		cpu(32'h0);
		chk(to_cpu_interrupt === 1'b1, "zero write kept");
		cpu(32'h2);
		chk(to_cpu_interrupt === 1'b0, "cpu clear");
		hw(32'h10);
		u_host.xfer(1'b0, 2'h0, 32'h0, q);
		chk(fetches == 1 && q[4] === 1'b0, "fetch");
		$display("irq and fetch test done");
		host_busy = 1'b1;
		cpu(32'h80);
		chk(port_ready === 1'b0 && cpu_rdata[7] === 1'b0, "srst hold");
		repeat (3) @(negedge sys_clk);
		chk(fifo_reset === 1'b0, "busy defers");
		host_busy = 1'b0;
		for (n = 0; fifo_reset !== 1'b1 && n < 20; n = n + 1) @(negedge sys_clk);
		chk(fifo_reset === 1'b1, "fifo reset start");
		if (n == 20) wrap_up;
		{cpu_wr, cpu_wdata} = {1'b1, 32'h0};
		for (n = 0; fifo_reset === 1'b1 && n < 20; n = n + 1) begin
			@(negedge sys_clk);
			cpu_wr = 1'b0;
		end
		chk(n == 4, "fifo reset length");
		cpu(32'h0);
		chk(port_ready === 1'b1, "ready back");
		dma_ready = 1'b0;
		#1;
		chk(port_ready === 1'b0, "ready follows");
		$display("soft reset test done");
		wrap_up;
	end
endmodule
bind hpc_control hpc_props u_props (.sys_clk, .rst, .host_busy, .cpu_wr, .cpu_wdata,
	.cpu_rdata, .port_ready, .fifo_reset, .read_address_reg, .write_address_reg,
	.to_host_interrupt, .to_cpu_interrupt);
